/* shared/irc_pkg.sv */
// constants, field layout and state encoding for the iso receive context control block
// assumes a classic wishbone slave port with 12 address bits and 32-bit data
package irc_pkg;

  // ==========================================================
  // register byte addresses, context 0
  localparam logic [11:0] ADR_CTRL_SET = 12'h400;
  localparam logic [11:0] ADR_CTRL_CLR = 12'h404;
  localparam logic [11:0] ADR_IRQ_STAT = 12'h410;
  localparam logic [11:0] ADR_IRQ_MASK = 12'h414;

  // ==========================================================
  // control register field positions
  localparam int BIT_PACKED  = 31;
  localparam int BIT_HEADER  = 30;
  localparam int BIT_SOC     = 29;
  localparam int BIT_MULTI   = 28;
  localparam int BIT_RUN     = 15;
  localparam int BIT_WAKE    = 12;
  localparam int BIT_DEAD    = 11;
  localparam int BIT_ACTIVE  = 10;
  localparam int SPD_LSB     = 5;
  localparam int EVT_LSB     = 0;

  // ==========================================================
  // reset values
  localparam logic       CTRL_BIT_RST = 1'b0;
  localparam logic [2:0] SPD_RST      = 3'h0;
  localparam logic [2:0] IRQ_RST      = 3'h0;
  localparam logic [31:0] DAT_RST     = 32'h0000_0000;

  // ==========================================================
  // receive speed codes
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h1;
  localparam logic [2:0] SPD_S400 = 3'h2;

  // ==========================================================
  // completion event codes, encodings are arbitrary
  localparam logic [4:0] EVT_ACK_COMPLETE   = 5'h01;
  localparam logic [4:0] EVT_ACK_DATA_ERROR = 5'h02;
  localparam logic [4:0] EVT_LONG_PACKET    = 5'h03;
  localparam logic [4:0] EVT_OVERRUN        = 5'h04;
  localparam logic [4:0] EVT_DESC_READ      = 5'h05;
  localparam logic [4:0] EVT_DATA_WRITE     = 5'h06;
  localparam logic [4:0] EVT_UNKNOWN        = 5'h0e;

  // ==========================================================
  // interrupt status and mask bits
  localparam int IRQ_ACTIVATED = 0;
  localparam int IRQ_DEAD      = 1;
  localparam int IRQ_PKT       = 2;

  // ==========================================================
  // context state, gray along idle, wait, active, dead
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_DEAD   = 2'b10
  } irc_state_t;

endpackage

/* src/irc_cycle_match.sv */
// start-on-cycle comparator for one iso receive context
// assumes cycle_start_i is a one-cycle pulse with the cycle number valid beside it
module irc_cycle_match (
  // cycle timer
  input  wire logic        cycle_start_i,
  input  wire logic [12:0] bus_cycle_number_i,
  // match register field
  input  wire logic [12:0] cycle_compare_value_i,
  // result
  output logic             hit_o
);

  // ==========================================================
  // compare
  // 13-bit compare on cycle start
  assign hit_o = cycle_start_i & (bus_cycle_number_i == cycle_compare_value_i);

endmodule

/* src/irc_ctrl.sv */
// control, status and interrupt logic of one isochronous receive dma context
// assumes a descriptor engine beside it giving fetch, fatal and packet done pulses,
// and mask and match registers held elsewhere
// ==========================================================
//
// Decided for this implementation: the register addresses and the Wishbone register port.
module irc_ctrl (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        soft_rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // cycle timer and match register
  input  wire logic        cycle_start_i,
  input  wire logic [12:0] bus_cycle_number_i,
  input  wire logic [12:0] cycle_compare_value_i,
  // channel filter
  input  wire logic [5:0]  pkt_channel_i,
  input  wire logic [5:0]  match_channel_i,
  input  wire logic [63:0] chan_mask_i,
  output logic             chan_accept_o,
  // descriptor engine
  input  wire logic        desc_fetch_i,
  input  wire logic        fatal_err_i,
  input  wire logic        pkt_done_i,
  input  wire logic [2:0]  pkt_speed_i,
  input  wire logic [4:0]  pkt_evt_i,
  input  wire logic        pkt_len_err_i,
  input  wire logic        pkt_crc_err_i,
  input  wire logic        pkt_overrun_i,
  output logic             active_o,
  output logic             wake_o,
  output logic             packed_buffer_mode_o,
  output logic             header_keep_o,
  output logic             pkt_discard_o,
  // interrupt
  output logic             irq_o
);

  // ==========================================================
  // functions
  function automatic logic nxt_bit(input logic cur, input logic s, input logic c);
    nxt_bit = s ? 1'b1 : (c ? 1'b0 : cur);
  endfunction

  function automatic logic [4:0] evt_filter(input logic [4:0] raw, input logic packed_m);
    case (raw)
      irc_pkg::EVT_ACK_COMPLETE,
      irc_pkg::EVT_DESC_READ,
      irc_pkg::EVT_DATA_WRITE: evt_filter = raw;
      irc_pkg::EVT_ACK_DATA_ERROR,
      irc_pkg::EVT_LONG_PACKET,
      irc_pkg::EVT_OVERRUN: evt_filter = packed_m ? irc_pkg::EVT_UNKNOWN : raw;
      default: evt_filter = irc_pkg::EVT_UNKNOWN;
    endcase
  endfunction

  // ==========================================================
  // declarations
  logic                packed_buffer_mode;
  logic                header_keep;
  logic                start_on_cycle_enable;
  logic                multi_channel_receive;
  logic                run;
  logic                wake;
  logic                dead;
  logic [2:0]          spd;
  logic [4:0]          evt;
  logic [2:0]          irq_stat;
  logic [2:0]          irq_mask;
  logic [2:0]          irq_evt;
  irc_pkg::irc_state_t state;
  irc_pkg::irc_state_t next_state;
  logic                cyc_hit;
  logic                go_active;
  logic                is_active;
  logic                pkt_ok;
  logic                req;
  logic [31:0]         wbits;
  logic [31:0]         set_b;
  logic [31:0]         clr_b;
  logic                wr_mask;
  logic                rd_stat;
  logic [31:0]         ctrl_rd;
  logic [31:0]         rdata;

  // ==========================================================
  // bus decode
  // one request per ack; ack falls the cycle after it rose
  assign req     = cyc_i & stb_i & ~ack_o;
  assign wbits   = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign set_b   = (req & we_i & (adr_i == irc_pkg::ADR_CTRL_SET)) ? wbits : 32'h0000_0000;
  assign clr_b   = (req & we_i & (adr_i == irc_pkg::ADR_CTRL_CLR)) ? wbits : 32'h0000_0000;
  assign wr_mask = req & we_i & (adr_i == irc_pkg::ADR_IRQ_MASK);
  assign rd_stat = req & ~we_i & (adr_i == irc_pkg::ADR_IRQ_STAT);

  // ==========================================================
  // cycle match
  irc_cycle_match u_match (
    .cycle_start_i         (cycle_start_i),
    .bus_cycle_number_i    (bus_cycle_number_i),
    .cycle_compare_value_i (cycle_compare_value_i),
    .hit_o                 (cyc_hit)
  );

  // ==========================================================
  // context state
  assign is_active = (state == irc_pkg::ST_ACTIVE);
  assign go_active = (next_state == irc_pkg::ST_ACTIVE) & ~is_active & ~soft_rst_i;

  always_comb begin
    next_state = state;
    case (state)
      irc_pkg::ST_IDLE: begin
        // defer start until cycle match
        // a dead flag left by a fatal in the stop cycle holds off a restart
        if (run && !dead) begin
          next_state = start_on_cycle_enable ? irc_pkg::ST_WAIT : irc_pkg::ST_ACTIVE;
        end
      end
      irc_pkg::ST_WAIT: begin
        if (!run) begin
          next_state = irc_pkg::ST_IDLE;
        end else if (cyc_hit) begin
          next_state = irc_pkg::ST_ACTIVE;
        end
      end
      irc_pkg::ST_ACTIVE: begin
        // fatal first, so a fatal in the stop cycle still lands in dead
        if (fatal_err_i) begin
          next_state = irc_pkg::ST_DEAD;
        end else if (!run) begin
          next_state = irc_pkg::ST_IDLE;
        end
      end
      irc_pkg::ST_DEAD: begin
        if (!run) begin
          next_state = irc_pkg::ST_IDLE;
        end
      end
      default: next_state = irc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst_i) begin
      state <= irc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // control bits
  // mode bits are plain set/clear; changing them mid-run is left to software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      packed_buffer_mode    <= irc_pkg::CTRL_BIT_RST;
      header_keep           <= irc_pkg::CTRL_BIT_RST;
      multi_channel_receive <= irc_pkg::CTRL_BIT_RST;
    end else begin
      packed_buffer_mode    <= nxt_bit(packed_buffer_mode, set_b[irc_pkg::BIT_PACKED],
                                       clr_b[irc_pkg::BIT_PACKED]);
      header_keep           <= nxt_bit(header_keep, set_b[irc_pkg::BIT_HEADER],
                                       clr_b[irc_pkg::BIT_HEADER]);
      multi_channel_receive <= nxt_bit(multi_channel_receive, set_b[irc_pkg::BIT_MULTI],
                                       clr_b[irc_pkg::BIT_MULTI]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_on_cycle_enable <= irc_pkg::CTRL_BIT_RST;
    end else begin
      start_on_cycle_enable <= nxt_bit(start_on_cycle_enable, set_b[irc_pkg::BIT_SOC],
                                       clr_b[irc_pkg::BIT_SOC] | go_active);
    end
  end

  // run moved only by software or resets
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst_i) begin
      run <= irc_pkg::CTRL_BIT_RST;
    end else begin
      run <= nxt_bit(run, set_b[irc_pkg::BIT_RUN], clr_b[irc_pkg::BIT_RUN]);
    end
  end

  // wake set by software, cleared by fetch
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst_i) begin
      wake <= irc_pkg::CTRL_BIT_RST;
    end else begin
      wake <= nxt_bit(wake, set_b[irc_pkg::BIT_WAKE], desc_fetch_i);
    end
  end

  // dead flag, the fatal set wins over a run clear, a soft reset wins over the fatal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dead <= irc_pkg::CTRL_BIT_RST;
    end else begin
      dead <= nxt_bit(dead, is_active & fatal_err_i & ~soft_rst_i,
                      clr_b[irc_pkg::BIT_RUN] | soft_rst_i);
    end
  end

  // ==========================================================
  // packet status
  assign pkt_ok = pkt_done_i & is_active;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd <= irc_pkg::SPD_RST;
    end else if (pkt_ok) begin
      spd <= pkt_speed_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt <= irc_pkg::EVT_UNKNOWN;
    end else if (pkt_ok) begin
      evt <= evt_filter(pkt_evt_i, packed_buffer_mode);
    end
  end

  // back out bad packets in packed mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_discard_o <= 1'b0;
    end else begin
      pkt_discard_o <= pkt_ok & packed_buffer_mode &
                       (pkt_len_err_i | pkt_crc_err_i | pkt_overrun_i);
    end
  end

  // ==========================================================
  // channel filter
  // multi-channel uses the masks
  // single channel uses the match channel
  assign chan_accept_o = is_active & (multi_channel_receive ? chan_mask_i[pkt_channel_i]
                                      : (pkt_channel_i == match_channel_i));

  assign active_o = is_active;
  assign wake_o   = wake;
  // buffer fill style to the engine
  assign packed_buffer_mode_o = packed_buffer_mode;
  assign header_keep_o        = header_keep;

  // ==========================================================
  // interrupts
  // a read clears status, but an event in that same cycle stays set
  assign irq_evt = {pkt_ok, is_active & fatal_err_i, go_active};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= irc_pkg::IRQ_RST;
    end else begin
      irq_stat <= irq_evt | (rd_stat ? irc_pkg::IRQ_RST : irq_stat);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= irc_pkg::IRQ_RST;
    end else if (wr_mask) begin
      irq_mask <= wbits[2:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ==========================================================
  // read back
  // reserved fields tied to zero
  assign ctrl_rd = {packed_buffer_mode, header_keep, start_on_cycle_enable,
                    multi_channel_receive, 12'h000, run, 2'b00, wake, dead,
                    is_active, 2'b00, spd, evt};

  always_comb begin
    case (adr_i)
      irc_pkg::ADR_CTRL_SET,
      irc_pkg::ADR_CTRL_CLR: rdata = ctrl_rd;
      irc_pkg::ADR_IRQ_STAT: rdata = {29'h0000_0000, irq_stat};
      irc_pkg::ADR_IRQ_MASK: rdata = {29'h0000_0000, irq_mask};
      default:               rdata = irc_pkg::DAT_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= irc_pkg::DAT_RST;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= rdata;
      end
    end
  end

  // ==========================================================
  // assertions
  resv_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_rd[27:16] == 12'h000) && (ctrl_rd[14:13] == 2'b00) && (ctrl_rd[9:8] == 2'b00))
    else $error("reserved control bits not zero");

  wait_match_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == irc_pkg::ST_WAIT) && !cyc_hit |=> !is_active)
    else $error("context started without cycle match");

  soc_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(is_active) && !$past(set_b[irc_pkg::BIT_SOC]) |-> !start_on_cycle_enable)
    else $error("start-on-cycle enable not cleared on activation");

  multi_acc_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_active && multi_channel_receive |-> chan_accept_o == chan_mask_i[pkt_channel_i])
    else $error("multi-channel accept wrong");

  single_acc_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !multi_channel_receive && (pkt_channel_i != match_channel_i) |-> !chan_accept_o)
    else $error("foreign channel accepted");

  run_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !soft_rst_i && !set_b[irc_pkg::BIT_RUN] && !clr_b[irc_pkg::BIT_RUN] |=> $stable(run))
    else $error("run changed without software or reset");

  wake_clr_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    desc_fetch_i && !set_b[irc_pkg::BIT_WAKE] |=> !wake)
    else $error("wake survived a descriptor fetch");

  dead_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_active && fatal_err_i && !soft_rst_i |=> dead && (state == irc_pkg::ST_DEAD))
    else $error("fatal error did not set dead");

  active_run_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_active |-> $past(run) && !dead)
    else $error("active without run");

  spd_latch_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pkt_ok |=> spd == $past(pkt_speed_i))
    else $error("speed field not updated");

  packed_evt_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pkt_ok && packed_buffer_mode && (pkt_evt_i == irc_pkg::EVT_OVERRUN)
    |=> evt == irc_pkg::EVT_UNKNOWN)
    else $error("packed mode reported a per-buffer code");

  backout_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pkt_ok && packed_buffer_mode && pkt_crc_err_i |=> pkt_discard_o)
    else $error("bad packet not backed out");

endmodule

/* sim/irc_engine_model.sv */
// descriptor engine stand-in for one iso receive context
// assumes active and wake levels from irc_ctrl; fetch latency set by the bench
module irc_engine_model (
  // system
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // context status
  input  wire logic       active_i,
  input  wire logic       wake_i,
  input  wire logic [3:0] lat_i,
  // fetch strobe
  output logic            desc_fetch_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // ==========================================================
  // descriptor fetch
  // fetch after a wake
  // lat_i of zero answers at once, larger values stall the fetch
  always_ff @(posedge clk_i) begin
    desc_fetch_o <= 1'b0;
    if (rst_i || !(active_i && wake_i) || desc_fetch_o) begin
      cnt <= 4'h0;
    end else if (cnt == lat_i) begin
      desc_fetch_o <= 1'b1;
      cnt          <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

/* sim/irc_ctrl_test.sv */
// self-checking bench for the iso receive context control block
// assumes an ack within 50 cycles on the register bus and a descriptor engine model beside it
module irc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        clk_i, rst_i, soft_rst_i, cyc_i, stb_i, we_i, ack_o, cycle_start_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i, lat_i;
  logic [31:0] dat_i, dat_o, rnd;
  logic [12:0] bus_cycle_number_i, cycle_compare_value_i, cmp;
  logic [5:0]  pkt_channel_i, match_channel_i;
  logic [63:0] chan_mask_i;
  logic        chan_accept_o, desc_fetch_i, fatal_err_i, pkt_done_i, active_o, wake_o;
  logic [2:0]  pkt_speed_i, lspd;
  logic [4:0]  pkt_evt_i, levt;
  logic        pkt_len_err_i, pkt_crc_err_i, pkt_overrun_i;
  logic        packed_buffer_mode_o, header_keep_o, pkt_discard_o, irq_o;
  int          n_mismatch, n_tests, k;
  logic [4:0]  codes [7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0e};

  irc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .cycle_start_i(cycle_start_i), .bus_cycle_number_i(bus_cycle_number_i),
    .cycle_compare_value_i(cycle_compare_value_i), .pkt_channel_i(pkt_channel_i),
    .match_channel_i(match_channel_i), .chan_mask_i(chan_mask_i),
    .chan_accept_o(chan_accept_o), .desc_fetch_i(desc_fetch_i), .fatal_err_i(fatal_err_i),
    .pkt_done_i(pkt_done_i), .pkt_speed_i(pkt_speed_i), .pkt_evt_i(pkt_evt_i),
    .pkt_len_err_i(pkt_len_err_i), .pkt_crc_err_i(pkt_crc_err_i),
    .pkt_overrun_i(pkt_overrun_i), .active_o(active_o), .wake_o(wake_o),
    .packed_buffer_mode_o(packed_buffer_mode_o), .header_keep_o(header_keep_o),
    .pkt_discard_o(pkt_discard_o), .irq_o(irq_o));
  irc_engine_model u_eng (.clk_i(clk_i), .rst_i(rst_i), .active_i(active_o),
    .wake_i(wake_o), .lat_i(lat_i), .desc_fetch_o(desc_fetch_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ==========================================================
  // helpers
  task automatic test_done;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, no latency assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {1'b1, 1'b1, w, a, d, 4'hf};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) n_mismatch++;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rnd);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rnd);
    chk(rnd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [4:0] exp_evt(input logic pk, input logic [4:0] c);
    logic ok;
    ok = c == 5'h01 || c == 5'h05 || c == 5'h06 || c == 5'h0e;
    if (!pk) ok = ok || c == 5'h02 || c == 5'h03 || c == 5'h04;
    return ok ? c : irc_pkg::EVT_UNKNOWN;
  endfunction
  task automatic pkt(input logic pk, input logic [4:0] c);
    logic [2:0] s, e;
    s = 3'($urandom_range(2, 0));
    e = 3'($urandom);
    @(posedge clk_i);
    {pkt_done_i, pkt_speed_i, pkt_evt_i} <= {1'b1, s, c};
    {pkt_len_err_i, pkt_crc_err_i, pkt_overrun_i} <= e;
    @(posedge clk_i);
    pkt_done_i <= 1'b0;
    #1;
    lspd = s;
    levt = exp_evt(pk, c);
    chk(pkt_discard_o, pk && e != 3'h0);
  endtask
  task automatic chan(input logic multi);
    logic [5:0] ch, m;
    ch = 6'($urandom);
    m = ($urandom_range(1, 0) != 0) ? ch : 6'($urandom);
    @(posedge clk_i);
    {pkt_channel_i, match_channel_i, chan_mask_i} <= {ch, m, $urandom, $urandom};
    #1;
    chk(chan_accept_o, multi ? chan_mask_i[ch] : ch == m);
  endtask
  task automatic cyc_pulse(input logic [12:0] n);
    @(posedge clk_i);
    {cycle_start_i, bus_cycle_number_i, cycle_compare_value_i} <= {1'b1, n, cmp};
    @(posedge clk_i);
    cycle_start_i <= 1'b0;
    #1;
  endtask
  task automatic pulse_fatal_soft(input logic f);
    @(posedge clk_i);
    {fatal_err_i, soft_rst_i} <= {f, !f};
    @(posedge clk_i);
    {fatal_err_i, soft_rst_i} <= 2'b00;
    #1;
  endtask
  // ==========================================================
  // watchdog, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    test_done;
  end
  // ==========================================================
  // main sequence
  initial begin
    rnd = $urandom(57653);
    {soft_rst_i, cyc_i, stb_i, we_i, cycle_start_i, fatal_err_i, pkt_done_i} = 7'h00;
    {adr_i, sel_i, lat_i, dat_i, bus_cycle_number_i, cycle_compare_value_i} = '0;
    {pkt_channel_i, match_channel_i, chan_mask_i, pkt_speed_i, pkt_evt_i} = '0;
    {pkt_len_err_i, pkt_crc_err_i, pkt_overrun_i, n_mismatch, n_tests} = '0;
    {lspd, levt} = {3'h0, 5'h0e};
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h400, 32'h0000_000e);
    rd(12'h420, 32'h0000_0000);
    rd(12'h414, 32'h0000_0000);
    wr(12'h400, 32'hc000_0000 | ($urandom & 32'h0fff_6300));
    chk(header_keep_o, 1'b1);
    wr(12'h410, 32'h0000_0007);
    rd(12'h400, 32'hc000_000e);
    wr(12'h404, 32'hc000_0000);
    chk(header_keep_o, 1'b0);
    rd(12'h400, 32'h0000_000e);
    rd(12'h410, 32'h0000_0000);
    wr(12'h414, 32'h0000_0004);
    wr(12'h400, 32'h0000_8000);
    tick(1);
    chk(active_o, 1'b1);
    rd(12'h410, 32'h0000_0001);
    lat_i <= 4'($urandom_range(7, 0));
    wr(12'h400, 32'h0000_1000);
    k = 0;
    while (wake_o !== 1'b0 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    rd(12'h400, 32'h0000_840e);
    for (int i = 0; i < 10; i++) begin
      pkt(1'b0, (i < 7) ? codes[i] : 5'($urandom));
      chk(irq_o, 1'b1);
      rd(12'h400, {24'h0000_84, lspd, levt});
      chan(1'b0);
    end
    rd(12'h410, 32'h0000_0004);
    chk(irq_o, 1'b0);
    pulse_fatal_soft(1'b1);
    chk(active_o, 1'b0);
    rd(12'h400, {24'h0000_88, lspd, levt});
    wr(12'h404, 32'h0000_8000);
    rd(12'h400, {24'h0000_00, lspd, levt});
    wr(12'h414, 32'h0000_0000);
    wr(12'h400, 32'h9000_0000);
    wr(12'h400, 32'h0000_8000);
    for (int i = 0; i < 12; i++) begin
      pkt(1'b1, (i < 7) ? codes[i] : 5'($urandom));
      chk(irq_o, 1'b0);
      rd(12'h400, {24'h9000_84, lspd, levt});
      chan(1'b1);
    end
    chk(packed_buffer_mode_o, 1'b1);
    wr(12'h404, 32'h0000_8000);
    tick(2);
    wr(12'h404, 32'h9000_0000);
    wr(12'h400, 32'h0000_8000);
    pulse_fatal_soft(1'b0);
    rd(12'h400, {24'h0000_00, lspd, levt});
    wr(12'h400, 32'h2000_0000);
    wr(12'h400, 32'h0000_8000);
    cmp = 13'($urandom);
    cyc_pulse(cmp ^ 13'h0001);
    chk(active_o, 1'b0);
    rd(12'h400, {24'h2000_80, lspd, levt});
    cyc_pulse(cmp);
    chk(active_o, 1'b1);
    rd(12'h400, {24'h0000_84, lspd, levt});
    test_done;
  end
endmodule
